// File: logic/admrb_cfg.svh
// Offsets, field positions, reset values and frame timing of the mode register bank
`ifndef ADMRB_CFG_SVH
`define ADMRB_CFG_SVH

`define ADMRB_IDX_ATT_L      7'h10
`define ADMRB_IDX_ATT_R      7'h11
`define ADMRB_IDX_FMT        7'h12
`define ADMRB_IDX_OUTF       7'h13
`define ADMRB_IDX_SYS        7'h14
`define ADMRB_IDX_ZOUT       7'h15
`define ADMRB_IDX_ZFLAG      7'h16
`define ADMRB_IDX_LINKID     7'h17

`define ADMRB_RST_ATT        8'hFF
`define ADMRB_RST_FMT        8'h50
`define ADMRB_RST_OUTF       8'h00
`define ADMRB_RST_SYS        8'h00
`define ADMRB_RST_ZOUT       8'h01

`define ADMRB_MASK_SYS       8'h7F
`define ADMRB_MASK_ZOUT      8'h07

`define ADMRB_B_OUT_DIS      4
`define ADMRB_B_PIN_FLAG     3
`define ADMRB_B_BYP_ST       2
`define ADMRB_B_ROLLOFF      1
`define ADMRB_B_ZMUTE        0
`define ADMRB_B_SOFT_SYSTEM_RESET         6
`define ADMRB_B_STREAM       5
`define ADMRB_B_BYPASS       4
`define ADMRB_B_MONO         3
`define ADMRB_B_CHSRC        2
`define ADMRB_B_SAMPLE_Z     0

`define ADMRB_FRAME_BITS     5'd16
`define ADMRB_RD_START_BIT   5'd8

`endif

// File: logic/admrb_pkg.sv
// Types shared by the mode register bank and its users
package admrb_pkg;

   // Control fields handed to the audio datapath
   typedef struct packed {
      logic [7:0] left_atten_level;
      logic [7:0] right_atten_level;
      logic [7:0] format_ctrl;
      logic       output_disable;
      logic       shared_pin_flag_select;
      logic       bypass_stereo_select;
      logic       rolloff_select;
      logic       continuous_zero_mute_enable;
      logic       soft_system_reset;
      logic       one_bit_stream_enable;
      logic       filter_bypass_enable;
      logic       mono_enable;
      logic       single_channel_source;
      logic [1:0] oversample_rate_sel;
      logic [1:0] deemph_rate_sel;
      logic [1:0] fir_rate_sel;
      logic [1:0] fir_perf_sel;
      logic       sample_zero_out_enable;
      logic [1:0] stream_zero_out_ctrl;
   } admrb_ctrl_s;

   typedef enum logic [1:0] {
      ADMRB_IDLE  = 2'b00,
      ADMRB_SHIFT = 2'b01,
      ADMRB_DONE  = 2'b10
   } admrb_state_e;

endpackage

// File: logic/admrb_top.sv
// Mode register bank behind the four-wire serial control port
//
// Summary of operation
// RQ1 - Word bit 15 high reads, low writes
// RQ2 - Indices 22 and 23 ignore writes
// RQ3 - Bits 14..8 pick index 16 to 23
// RQ4 - Index 19 bit 4 disables both outputs
// RQ5 - Index 19 bit 3 selects shared pin role
// RQ6 - Index 19 bit 2 stereo bypass, bypass only
// RQ7 - Index 19 bit 1 selects filter rolloff
// RQ8 - Index 19 bit 0 enables zero-input mute
// RQ9 - Index 20 bit 6 commands system reset
// RQ10 - Index 20 bit 5 enables one-bit stream
// RQ11 - Index 20 bit 4 bypasses digital filter
// RQ12 - Index 20 bits 3,2 mono and source
// RQ13 - Index 20 bits 1..0 oversampling rate
// RQ14 - Stream mode: rate field sets FIR rate
// RQ15 - Stream mode: de-emphasis field sets FIR setting
// RQ16 - Index 21 bit 0 sample zero output
// RQ17 - Index 21 bits 2..1 stream zero output
// RQ18 - Index 22 reports left/right zero flags
// RQ19 - Index 23 returns five-bit link identifier
// RQ20 - One 16-bit word, MSB first per frame
// RQ21 - Read data driven after eighth clock
// RQ22 - Write data latched after sixteenth clock
// RQ23 - Host raises select between frames
// RQ24 - Reserved bits read zero, ignore writes; index 19 bits 7..5 are stored and read back
`timescale 1ns/1ps
`include "admrb_cfg.svh"

module admrb_top (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   // Serial control port pins
   input  wire logic                 i_control_select_n,
   input  wire logic                 i_control_bit_clock,
   input  wire logic                 i_control_serial_in,
   output logic                      o_control_serial_out,
   output logic                      o_control_serial_out_oe,
   // Datapath status
   input  wire logic                 i_left_zero_flag,
   input  wire logic                 i_right_zero_flag,
   input  wire logic [4:0]           i_link_node_identifier,
   // Control fields
   output admrb_pkg::admrb_ctrl_s    o_ctrl
);
   import admrb_pkg::*;

   // Index decode, shared by the read and write paths
   function automatic logic idx_is(input logic [6:0] idx, input logic [6:0] want);
      idx_is = (idx == want);
   endfunction

   // Synchronisers; stage one feeds only stage two
   logic [2:0]   sel_sync_r;
   logic [2:0]   clk_sync_r;
   logic [1:0]   din_sync_r;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sel_sync_r <= 3'h7;
         clk_sync_r <= 3'h0;
         din_sync_r <= 2'h0;
      end else begin
         sel_sync_r <= {sel_sync_r[1:0], i_control_select_n};
         clk_sync_r <= {clk_sync_r[1:0], i_control_bit_clock};
         din_sync_r <= {din_sync_r[0], i_control_serial_in};
      end
   end

   wire sel_n     = sel_sync_r[1];
   wire sck_rise  = clk_sync_r[1] & ~clk_sync_r[2];
   wire sck_fall  = ~clk_sync_r[1] & clk_sync_r[2];
   wire sdi       = din_sync_r[1];

   // Register storage
   logic [7:0]   att_l_r;
   logic [7:0]   att_r_r;
   logic [7:0]   fmt_r;
   logic [7:0]   outf_r;
   logic [7:0]   sys_r;
   logic [7:0]   zout_r;

   // Frame state
   admrb_state_e state_r;
   admrb_state_e state_nxt;
   logic [4:0]   bit_cnt_r;
   logic [14:0]  shift_in_r;
   logic [7:0]   shift_out_r;
   logic         out_en_r;

   // The word so far, with the bit arriving on this edge appended
   wire  [15:0]  word_now   = {shift_in_r, sdi};
   wire  [4:0]   bit_cnt_nx = bit_cnt_r + 5'd1;
   wire          take_bit   = (state_r == ADMRB_SHIFT) & sck_rise;
   wire          rd_point   = take_bit & (bit_cnt_nx == `ADMRB_RD_START_BIT);
   wire          frame_end  = take_bit & (bit_cnt_nx == `ADMRB_FRAME_BITS);
   wire          is_read    = shift_in_r[6];              // [RQ1]
   wire  [6:0]   rd_idx     = {shift_in_r[5:0], sdi};     // [RQ3]
   wire  [6:0]   wr_idx     = word_now[14:8];             // [RQ3]
   wire  [7:0]   wr_data    = word_now[7:0];              // [RQ20]
   wire          do_write   = frame_end & ~word_now[15];  // [RQ1] [RQ22]

   // Select high ends any frame; a frame that ran its 16 bits waits for it
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ADMRB_IDLE: begin
            if (!sel_n) begin
               state_nxt = ADMRB_SHIFT;
            end
         end
         ADMRB_SHIFT: begin
            if (sel_n) begin
               state_nxt = ADMRB_IDLE;
            end else if (frame_end) begin
               state_nxt = ADMRB_DONE;
            end
         end
         ADMRB_DONE: begin
            if (sel_n) begin
               state_nxt = ADMRB_IDLE;                    // [RQ23]
            end
         end
         default: begin
            state_nxt = ADMRB_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= ADMRB_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || state_r != ADMRB_SHIFT) begin
         bit_cnt_r  <= 5'h00;
         shift_in_r <= 15'h0000;
      end else if (sck_rise) begin
         bit_cnt_r  <= bit_cnt_nx;
         shift_in_r <= word_now[14:0];                    // [RQ20]
      end
   end

   // Readback mux; reserved bits of indices 20 to 23 come back as zero, index 19 returns all eight bits
   logic [7:0]   rd_val;

   always_comb begin
      rd_val = 8'h00;
      if (idx_is(rd_idx, `ADMRB_IDX_ATT_L)) begin
         rd_val = att_l_r;
      end else if (idx_is(rd_idx, `ADMRB_IDX_ATT_R)) begin
         rd_val = att_r_r;
      end else if (idx_is(rd_idx, `ADMRB_IDX_FMT)) begin
         rd_val = fmt_r;
      end else if (idx_is(rd_idx, `ADMRB_IDX_OUTF)) begin
         rd_val = outf_r;
      end else if (idx_is(rd_idx, `ADMRB_IDX_SYS)) begin
         rd_val = sys_r & `ADMRB_MASK_SYS;                // [RQ24]
      end else if (idx_is(rd_idx, `ADMRB_IDX_ZOUT)) begin
         rd_val = zout_r & `ADMRB_MASK_ZOUT;              // [RQ24]
      end else if (idx_is(rd_idx, `ADMRB_IDX_ZFLAG)) begin
         rd_val = {6'h00, i_right_zero_flag, i_left_zero_flag};  // [RQ18]
      end else if (idx_is(rd_idx, `ADMRB_IDX_LINKID)) begin
         rd_val = {3'h0, i_link_node_identifier};         // [RQ19]
      end
   end

   // Readback: first data bit stands from the eighth rising edge,
   // later bits move on each falling edge after the ninth rising edge, as a host samples on rising
   always_ff @(posedge i_clk) begin
      if (i_rst || state_r == ADMRB_IDLE || sel_n) begin
         shift_out_r <= 8'h00;
         out_en_r    <= 1'b0;
      end else if (rd_point && is_read) begin
         shift_out_r <= rd_val;                           // [RQ21]
         out_en_r    <= 1'b1;
      end else if (out_en_r && sck_fall && bit_cnt_r > `ADMRB_RD_START_BIT) begin
         shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
   end

   assign o_control_serial_out    = shift_out_r[7];
   assign o_control_serial_out_oe = out_en_r;

   // Writes land only after the last bit; unmapped and read-only indices drop.
   // Indices 22 and 23 have no storage and no strobe, so writes there are lost [RQ2]
   wire          wr_att_l   = do_write & idx_is(wr_idx, `ADMRB_IDX_ATT_L);  // [RQ22]
   wire          wr_att_r   = do_write & idx_is(wr_idx, `ADMRB_IDX_ATT_R);  // [RQ22]
   wire          wr_fmt     = do_write & idx_is(wr_idx, `ADMRB_IDX_FMT);    // [RQ22]
   wire          wr_outf    = do_write & idx_is(wr_idx, `ADMRB_IDX_OUTF);   // [RQ22]
   wire          wr_sys     = do_write & idx_is(wr_idx, `ADMRB_IDX_SYS);    // [RQ22]
   wire          wr_zout    = do_write & idx_is(wr_idx, `ADMRB_IDX_ZOUT);   // [RQ22]

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         att_l_r <= `ADMRB_RST_ATT;
      end else if (wr_att_l) begin
         att_l_r <= wr_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         att_r_r <= `ADMRB_RST_ATT;
      end else if (wr_att_r) begin
         att_r_r <= wr_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fmt_r <= `ADMRB_RST_FMT;
      end else if (wr_fmt) begin
         fmt_r <= wr_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         outf_r <= `ADMRB_RST_OUTF;                       // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8]
      end else if (wr_outf) begin
         outf_r <= wr_data;
      end
   end

   // Reserved bits of indices 20 and 21 are never stored, so they cannot alter hidden behaviour
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sys_r <= `ADMRB_RST_SYS;                         // [RQ9] [RQ10] [RQ11] [RQ12] [RQ13]
      end else if (wr_sys) begin
         sys_r <= wr_data & `ADMRB_MASK_SYS;              // [RQ24]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         zout_r <= `ADMRB_RST_ZOUT;                       // [RQ16] [RQ17]
      end else if (wr_zout) begin
         zout_r <= wr_data & `ADMRB_MASK_ZOUT;            // [RQ24]
      end
   end

   // Field decode toward the datapath
   wire stream_on = sys_r[`ADMRB_B_STREAM];               // [RQ10]
   wire bypass_on = sys_r[`ADMRB_B_BYPASS];               // [RQ11]

   admrb_ctrl_s  ctrl_nxt;

   always_comb begin
      ctrl_nxt                             = '0;
      ctrl_nxt.left_atten_level            = att_l_r;
      ctrl_nxt.right_atten_level           = att_r_r;
      ctrl_nxt.format_ctrl                 = fmt_r;
      ctrl_nxt.output_disable              = outf_r[`ADMRB_B_OUT_DIS];   // [RQ4]
      ctrl_nxt.shared_pin_flag_select      = outf_r[`ADMRB_B_PIN_FLAG];  // [RQ5]
      // Stereo bypass selection has meaning only with the filter bypassed
      ctrl_nxt.bypass_stereo_select        = outf_r[`ADMRB_B_BYP_ST] & bypass_on;  // [RQ6]
      // Rolloff belongs to multi-bit sample input only
      ctrl_nxt.rolloff_select              = outf_r[`ADMRB_B_ROLLOFF] & ~stream_on; // [RQ7]
      ctrl_nxt.continuous_zero_mute_enable = outf_r[`ADMRB_B_ZMUTE] & ~stream_on;   // [RQ8]
      ctrl_nxt.soft_system_reset           = sys_r[`ADMRB_B_SOFT_SYSTEM_RESET];       // [RQ9]
      ctrl_nxt.one_bit_stream_enable       = stream_on;                  // [RQ10]
      ctrl_nxt.filter_bypass_enable        = bypass_on;                  // [RQ11]
      ctrl_nxt.mono_enable                 = sys_r[`ADMRB_B_MONO];       // [RQ12]
      ctrl_nxt.single_channel_source       = sys_r[`ADMRB_B_CHSRC];      // [RQ12]
      if (stream_on) begin
         ctrl_nxt.fir_rate_sel             = sys_r[1:0];                 // [RQ14]
         ctrl_nxt.fir_perf_sel             = fmt_r[3:2];                 // [RQ15]
         ctrl_nxt.stream_zero_out_ctrl     = zout_r[2:1];                // [RQ17]
      end else begin
         ctrl_nxt.oversample_rate_sel      = sys_r[1:0];                 // [RQ13]
         ctrl_nxt.deemph_rate_sel          = fmt_r[3:2];
         ctrl_nxt.sample_zero_out_enable   = zout_r[`ADMRB_B_SAMPLE_Z];  // [RQ16]
      end
   end

   // Registered so the datapath never sees decode glitches
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ctrl <= '0;
      end else begin
         o_ctrl <= ctrl_nxt;
      end
   end

endmodule

// File: tb/admrb_host.sv
// Host model that runs frames on the serial control port
`timescale 1ns/1ps
module admrb_host (
   // Clock and readback
   input  wire logic i_clk,
   input  wire logic i_control_serial_out,
   // Port pins
   output logic      o_control_select_n,
   output logic      o_control_bit_clock,
   output logic      o_control_serial_in
);
   initial begin
      o_control_select_n = 1'b1;
      o_control_bit_clock = 1'b0;
      o_control_serial_in = 1'b0;
   end
   task automatic half();
      repeat (5) @(negedge i_clk);
   endtask
   // Frame of n bits, MSB first; n below 16 aborts
   task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
      rd = 8'h00;
      o_control_select_n = 1'b0;
      half();
      for (int i = 15; i >= 16 - n; i--) begin
         o_control_serial_in = w[i];
         half();
         o_control_bit_clock = 1'b1;
         if (i < 8) rd = {rd[6:0], i_control_serial_out};
         half();
         o_control_bit_clock = 1'b0;
      end
      half();
      o_control_select_n = 1'b1;
      // Released data line must not look like the last bit
      o_control_serial_in = ~o_control_serial_in;
      half();
   endtask
endmodule

// File: tb/admrb_monitor.sv
// Port checker for the mode register bank
`timescale 1ns/1ps
module admrb_monitor (
   // Clock and reset
   input wire logic                  i_clk,
   input wire logic                  i_rst,
   // Serial port
   input wire logic                  i_control_select_n,
   input wire logic                  i_control_bit_clock,
   input wire logic                  o_control_serial_out,
   input wire logic                  o_control_serial_out_oe,
   // Control fields
   input wire admrb_pkg::admrb_ctrl_s o_ctrl
);
   import admrb_pkg::*;
   logic       sck_q;
   logic [4:0] rise_cnt;
   // Counts bit clock rises at the pin, so timing is judged before the sync stages
   always_ff @(posedge i_clk) begin
      sck_q <= i_control_bit_clock;
      if (i_rst || i_control_select_n) rise_cnt <= 5'h00;
      else if (i_control_bit_clock && !sck_q) rise_cnt <= rise_cnt + 5'h01;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_oe_eighth;
      $rose(o_control_serial_out_oe) |-> rise_cnt == 5'h08 && !i_control_select_n;
   endproperty
   a_oe_eighth: assert property (p_oe_eighth) else $error("readback off clock 8");
   property p_quiet;
      !o_control_serial_out_oe |-> !o_control_serial_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output not quiet");
   property p_release;
      i_control_select_n [*5] |-> !o_control_serial_out_oe;
   endproperty
   a_release: assert property (p_release) else $error("drive kept");
   property p_hold;
      $fell(o_control_serial_out_oe) |-> $past(i_control_select_n);
   endproperty
   a_hold: assert property (p_hold) else $error("drive dropped early");
   property p_wr_time;
      !$stable(o_ctrl) && !$past(i_rst, 2) |-> rise_cnt == 5'h10;
   endproperty
   a_wr_time: assert property (p_wr_time) else $error("write off clock 16");
   property p_rst_val;
      $fell(i_rst) |=> o_ctrl.left_atten_level == 8'hFF && o_ctrl.format_ctrl == 8'h50
         && o_ctrl.sample_zero_out_enable && !o_ctrl.output_disable;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("bad reset value");
   property p_stream;
      o_ctrl.one_bit_stream_enable |-> !o_ctrl.rolloff_select && !o_ctrl.sample_zero_out_enable;
   endproperty
   a_stream: assert property (p_stream) else $error("stream gating");
   property p_pcm;
      !o_ctrl.one_bit_stream_enable |-> o_ctrl.fir_rate_sel == 2'h0
         && o_ctrl.stream_zero_out_ctrl == 2'h0;
   endproperty
   a_pcm: assert property (p_pcm) else $error("sample gating");
   property p_byp;
      o_ctrl.bypass_stereo_select |-> o_ctrl.filter_bypass_enable;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass gating");
endmodule
bind admrb_top admrb_monitor mon (
   .i_clk(i_clk),
   .i_rst(i_rst),
   .i_control_select_n(i_control_select_n),
   .i_control_bit_clock(i_control_bit_clock),
   .o_control_serial_out(o_control_serial_out),
   .o_control_serial_out_oe(o_control_serial_out_oe),
   .o_ctrl(o_ctrl)
);

// File: tb/test_audio_dac_mode_register_bank.sv
// Self-checking bench for the mode register bank
`timescale 1ns/1ps
`include "admrb_cfg.svh"
module test_audio_dac_mode_register_bank;
   import admrb_pkg::*;
   logic        clk, rst, sel_n, sck, sdi, zl, zr, sdo_last;
   logic [4:0]  id;
   logic        out, oe, sdo_w;
   admrb_ctrl_s ctrl;
   int          errors, check_count;
   int          cyc = 0;
   logic [31:0] lfsr = 32'h0055BCAD;
   logic [31:0] r;
   logic [7:0]  rd;
   logic [7:0]  mdl [16:23];
   admrb_top dut (.i_clk(clk), .i_rst(rst), .i_control_select_n(sel_n),
      .i_control_bit_clock(sck), .i_control_serial_in(sdi), .o_control_serial_out(out),
      .o_control_serial_out_oe(oe), .i_left_zero_flag(zl), .i_right_zero_flag(zr),
      .i_link_node_identifier(id), .o_ctrl(ctrl));
   admrb_host host (.i_clk(clk), .i_control_serial_out(sdo_w), .o_control_select_n(sel_n),
      .o_control_bit_clock(sck), .o_control_serial_in(sdi));
   assign sdo_w = oe ? out : ~sdo_last;
   always @(posedge clk) if (oe) sdo_last <= out;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         end_of_test();
      end
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic admrb_ctrl_s exp_ctrl();
      logic s;
      s = mdl[20][5];
      return '{mdl[16], mdl[17], mdl[18], mdl[19][4], mdl[19][3], mdl[19][2] & mdl[20][4],
         mdl[19][1] & !s, mdl[19][0] & !s, mdl[20][6], s, mdl[20][4], mdl[20][3], mdl[20][2],
         s ? 2'h0 : mdl[20][1:0], s ? 2'h0 : mdl[18][3:2], s ? mdl[20][1:0] : 2'h0,
         s ? mdl[18][3:2] : 2'h0, mdl[21][0] & !s, s ? mdl[21][2:1] : 2'h0};
   endfunction
   task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected read at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic cmp_ctrl(input admrb_ctrl_s g, input admrb_ctrl_s e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected ctrl at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [6:0] ix, input logic [7:0] d);
      host.xfer({1'b0, ix, d}, 16, rd);
      if (ix inside {[7'h10:7'h15]}) mdl[ix] = d & (ix == 7'h14 ? `ADMRB_MASK_SYS :
         ix == 7'h15 ? `ADMRB_MASK_ZOUT : 8'hFF);
      cmp_ctrl(ctrl, exp_ctrl());
   endtask
   task automatic rdchk(input logic [6:0] ix);
      logic [7:0] e;
      r = rnd();
      {id, zr, zl} = r[6:0];
      e = ix inside {[7'h10:7'h15]} ? mdl[ix] : 8'h00;
      if (ix == 7'h16) e = {6'h00, zr, zl};
      if (ix == 7'h17) e = {3'h0, id};
      host.xfer({1'b1, ix, 8'h00}, 16, rd);
      cmp_rd(rd, e);
   endtask
   task automatic end_of_test();
      $display("errors %0d check_count %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      {errors, check_count} = '0;
      {rst, zl, zr, id, sdo_last} = 9'h100;
      mdl = '{`ADMRB_RST_ATT, `ADMRB_RST_ATT, `ADMRB_RST_FMT, `ADMRB_RST_OUTF,
         `ADMRB_RST_SYS, `ADMRB_RST_ZOUT, 8'h00, 8'h00};
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      cmp_ctrl(ctrl, exp_ctrl());
      for (int i = 16; i < 24; i++) rdchk(7'(i));
      $display("test reset done");
      repeat (2) for (int i = 16; i < 22; i++) begin
         r = rnd();
         wr(7'(i), r[7:0]);
         rdchk(7'(i));
      end
      $display("test write done");
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         wr(7'h13, r[7:0] | 8'h04);
         wr(7'h14, {r[15:14], k[2], ~k[2], r[11:10], k[1:0]});
      end
      $display("test modes done");
      r = rnd();
      wr(7'h16, r[7:0]);
      wr(7'h17, r[15:8]);
      wr(7'h30, r[23:16]);
      rdchk(7'h16);
      rdchk(7'h30);
      host.xfer({1'b0, 7'h10, ~mdl[16]}, 12, rd);
      rdchk(7'h10);
      $display("test refuse done");
      end_of_test();
   end
endmodule
